// file: common/tap_map.svh
// tap_map.svh: encodings, reset values and counts of the scan access port
// assumes: included by its bare name from the port design and the bench
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

`define TAP_IR_W 4
`define TAP_IR_BYPASS 4'hf
`define TAP_IR_IDCODE 4'h2
`define TAP_IR_CAPTURE 2'b01
`define TAP_ID_W 32
// identification value is arbitrary; bit 0 must stay set
`define TAP_ID_VALUE 32'h0a5c3001
`define TAP_RESET_ONES 3'h5

`endif

// file: common/tap_pkg.sv
// tap_pkg: types shared by the scan access port files
// assumes: compiled before the design files
package tap_pkg;

  // sixteen controller states, in no particular code
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr,
    st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_t;

  // scan pins as they arrive from the board
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scan_pins_t;

endpackage

// file: verilog/tap_sync.sv
// tap_sync: two-flop synchroniser, one stage pair per bit
// assumes: inputs are asynchronous to clk; output settles two edges later
`timescale 1ns/1ps
`default_nettype none

module tap_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stab_q;
      // reset to the idle high level of the pulled-up pins, so that no
      // false edge is seen when reset lets go
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end else begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate

endmodule

`default_nettype wire

// file: verilog/tap_port.sv
// tap_port: boundary-scan access port with instruction, identification and bypass registers
// assumes: clk far faster than the scan clock, which is sampled as a plain input
//
// Summary of operation
// RQ1: on scan-clock rise in a shift state, serial input enters the selected register
// RQ2: serial output changes on scan-clock fall from the selected register
// RQ3: serial output driven only in data or instruction shift state
// RQ4: mode select steers the controller through its states on each rise
// RQ5: test reset puts the controller into reset at once, no scan-clock edge needed
// RQ6: no reset at power-up; test reset or five high mode-select clocks resets it
// RQ7: serial output stays undriven until the controller has been reset
// RQ8: board ties the test reset to the device master reset when unused
// RQ9: inputs sampled on scan-clock rise, outputs changed only on fall
// RQ10: controller follows the standard sixteen-state sequence
`timescale 1ns/1ps
`default_nettype none

`include "tap_map.svh"

module tap_port #(
  parameter int IR_W = `TAP_IR_W,
  parameter int ID_W = `TAP_ID_W,
  parameter logic [`TAP_ID_W-1:0] ID_VALUE = `TAP_ID_VALUE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // scan pins from the test controller
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  // serial output, three-state
  output logic tdo,
  output logic tdo_oe,
  // status
  output logic tap_ready,
  output logic [IR_W-1:0] instr
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  tap_pkg::scan_pins_t pins_raw;
  tap_pkg::scan_pins_t pins_s;
  logic tck_prev_q;
  logic tck_rise;
  logic tck_fall;
  logic trst_meta_q;
  logic trst_ok_q;
  logic tap_rst;

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

  tap_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // test reset clears at once and releases through two flops, so the
  // controller never leaves reset on a half-settled level; the chip reset
  // sets them instead, so that it never passes for a test reset
  always_ff @(posedge clk or posedge rst or negedge trst_n) begin
    if (!trst_n) begin
      trst_meta_q <= 1'b0;
      trst_ok_q <= 1'b0;
    end else if (rst) begin
      trst_meta_q <= 1'b1;
      trst_ok_q <= 1'b1;
    end else begin
      trst_meta_q <= 1'b1;
      trst_ok_q <= trst_meta_q;
    end
  end

  assign tap_rst = rst | ~trst_ok_q; // RQ5

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_prev_q <= 1'b1;
    end else begin
      tck_prev_q <= pins_s.tck;
    end
  end

  assign tck_rise = pins_s.tck & ~tck_prev_q; // RQ9
  assign tck_fall = ~pins_s.tck & tck_prev_q; // RQ9

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  tap_pkg::tap_state_t state_q;
  tap_pkg::tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tap_pkg::st_reset: state_d = pins_s.tms ? tap_pkg::st_reset : tap_pkg::st_idle;
      tap_pkg::st_idle: state_d = pins_s.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_dr: state_d = pins_s.tms ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
      tap_pkg::st_cap_dr: state_d = pins_s.tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_shift_dr: state_d = pins_s.tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_exit1_dr: state_d = pins_s.tms ? tap_pkg::st_upd_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_pause_dr: state_d = pins_s.tms ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_exit2_dr: state_d = pins_s.tms ? tap_pkg::st_upd_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_upd_dr: state_d = pins_s.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_ir: state_d = pins_s.tms ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
      tap_pkg::st_cap_ir: state_d = pins_s.tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_shift_ir: state_d = pins_s.tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_exit1_ir: state_d = pins_s.tms ? tap_pkg::st_upd_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_pause_ir: state_d = pins_s.tms ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_exit2_ir: state_d = pins_s.tms ? tap_pkg::st_upd_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_upd_ir: state_d = pins_s.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
    endcase
  end // RQ10

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      state_q <= tap_pkg::st_reset;
    end else if (tck_rise) begin
      state_q <= state_d; // RQ4
    end
  end

  // the chip reset alone does not count as a controller reset: only the
  // test reset or a pass through the reset state opens the output
  logic ready_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else if (!trst_ok_q || (tck_rise && state_q == tap_pkg::st_reset)) begin
      ready_q <= 1'b1; // RQ6
    end
  end

  // ----------------------------------------------------------------
  // instruction and data registers
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  logic [ID_W-1:0] id_sh_q;
  logic bypass_q;
  logic sel_id;
  logic shift_now;
  logic out_bit;

  assign sel_id = (ir_q == IR_W'(`TAP_IR_IDCODE));
  assign shift_now = (state_q == tap_pkg::st_shift_dr) || (state_q == tap_pkg::st_shift_ir);

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sh_q <= '0;
    end else if (tck_rise) begin
      if (state_q == tap_pkg::st_cap_ir) begin
        ir_sh_q <= {{(IR_W-2){1'b0}}, `TAP_IR_CAPTURE};
      end else if (state_q == tap_pkg::st_shift_ir) begin
        ir_sh_q <= {pins_s.tdi, ir_sh_q[IR_W-1:1]}; // RQ1
      end
    end
  end

  // identification is the instruction after a chip or test reset; a pass through the reset state keeps the current one
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_q <= IR_W'(`TAP_IR_IDCODE);
    end else if (tck_rise && state_q == tap_pkg::st_upd_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  // any code other than identification selects bypass, so unknown codes are safe
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      id_sh_q <= '0;
      bypass_q <= 1'b0;
    end else if (tck_rise) begin
      if (state_q == tap_pkg::st_cap_dr) begin
        id_sh_q <= ID_VALUE;
        bypass_q <= 1'b0;
      end else if (state_q == tap_pkg::st_shift_dr) begin
        if (sel_id) begin
          id_sh_q <= {pins_s.tdi, id_sh_q[ID_W-1:1]}; // RQ1
        end else begin
          bypass_q <= pins_s.tdi; // RQ1
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  always_comb begin
    if (state_q == tap_pkg::st_shift_ir) begin
      out_bit = ir_sh_q[0];
    end else if (sel_id) begin
      out_bit = id_sh_q[0];
    end else begin
      out_bit = bypass_q;
    end
  end

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= out_bit; // RQ2
      tdo_oe <= shift_now && ready_q; // RQ3 RQ7
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_ready <= 1'b0;
      instr <= IR_W'(`TAP_IR_IDCODE);
    end else begin
      tap_ready <= ready_q;
      instr <= ir_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] ones_q;

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ones_q <= '0;
    end else if (tck_rise) begin
      ones_q <= !pins_s.tms ? 3'h0 : (ones_q == `TAP_RESET_ONES) ? ones_q : ones_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (tap_rst);

  a_oe_shift_only: assert property (tck_fall |=> tdo_oe == $past(shift_now && ready_q)) // RQ3
    else $error("output enable not tied to shift state");
  a_tdo_fall_only: assert property (!tck_fall |=> $stable(tdo) && $stable(tdo_oe)) // RQ9
    else $error("serial output moved off a falling edge");
  a_tdo_value: assert property (tck_fall |=> tdo == $past(out_bit)) // RQ2
    else $error("serial output not taken from selected register");
  a_hiz_unreset: assert property (!ready_q |-> !tdo_oe) // RQ7
    else $error("output driven before controller reset");
  a_five_ones: assert property (ones_q == `TAP_RESET_ONES |-> state_q == tap_pkg::st_reset) // RQ6
    else $error("five high mode-select clocks did not reset");
  a_state_rise: assert property (!tck_rise |=> $stable(state_q)) // RQ4
    else $error("controller moved without a scan-clock rise");
  a_reset_exit: assert property (tck_rise && state_q == tap_pkg::st_reset && !pins_s.tms
                                 |=> state_q == tap_pkg::st_idle) // RQ10
    else $error("reset state did not go to idle");
  a_bypass_shift: assert property (tck_rise && state_q == tap_pkg::st_shift_dr && !sel_id
                                   |=> bypass_q == $past(pins_s.tdi)) // RQ1
    else $error("bypass did not take serial input");
  a_ir_capture: assert property (tck_rise && state_q == tap_pkg::st_cap_ir
                                 |=> ir_sh_q[1:0] == `TAP_IR_CAPTURE) // RQ10
    else $error("instruction capture pattern wrong");
  a_trst_now: assert property (@(posedge clk) disable iff (rst)
                               !trst_n |=> state_q == tap_pkg::st_reset && !tdo_oe) // RQ5
    else $error("test reset did not reset controller");

endmodule

`default_nettype wire

// file: dv/scan_ctrl_model.sv
// scan_ctrl_model: behavioural test controller that clocks the scan port
// assumes: paced by the system clock; the scan clock stands high between frames
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model (
  // pacing clock
  input wire logic clk,
  // scan pins toward the port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // pins idle at their pull-up level
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ----------------------------------------------------------------
  // one scan-clock period of 13 clk
  // ----------------------------------------------------------------
  // tms/tdi change at the fall and go back high 6 clk after the rise, so they stand well around the rise
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge clk);
    o = tdo_oe ? tdo : 1'bz;
    oe = tdo_oe;
    tck <= 1'b1;
    repeat (6) @(posedge clk);
    tms <= 1'b1;
    tdi <= 1'b1;
  endtask

  // reaches the reset state from anywhere
  task automatic five_high();
    logic o;
    logic oe;
    repeat (5) step(1'b1, 1'b1, o, oe);
  endtask
endmodule

`default_nettype wire

// file: dv/tb.sv
// tb: self-checking bench for the scan access port
// assumes: the model drives the scan pins; the bench owns both resets
`timescale 1ns/1ps
`default_nettype none

`include "tap_map.svh"

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trst_n = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, tap_ready;
  logic [`TAP_IR_W-1:0] instr;
  logic [31:0] dout;
  logic oe_all, oe_exit, o, oe;
  int num_errors = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  tap_port i_tap_port (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .tap_ready(tap_ready), .instr(instr));
  scan_ctrl_model i_scan_ctrl_model (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // tms bits are taken lsb first
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      i_scan_ctrl_model.step(m[i], 1'b1, o, oe);
    end
  endtask

  // shift n bits from a shift state, then exit, update and back to idle
  task automatic scan(input logic [31:0] din, input int n);
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      i_scan_ctrl_model.step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all = oe_all & oe;
    end
    i_scan_ctrl_model.step(1'b1, 1'b1, o, oe_exit);
    i_scan_ctrl_model.step(1'b0, 1'b1, o, oe);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    repeat (10) @(posedge clk);
    chk("ready_before_reset", 32'h0, tap_ready);
    chk("oe_before_reset", 32'h0, tdo_oe);
  endtask

  task automatic t_five_high();
    i_scan_ctrl_model.five_high();
    chk("ready_after_tms", 32'h1, tap_ready);
    chk("instr_after_tms", `TAP_IR_IDCODE, instr);
  endtask

  task automatic t_id_read();
    walk(8'h02, 4);
    scan(32'hffff_ffff, 32);
    chk("id_value", `TAP_ID_VALUE, dout);
    chk("oe_in_shift", 32'h1, oe_all);
    chk("oe_in_exit", 32'h0, oe_exit);
  endtask

  task automatic t_ir_bypass();
    walk(8'h03, 4);
    scan(32'h0000_000f, 4);
    chk("ir_capture", `TAP_IR_CAPTURE, dout);
    chk("instr_bypass", `TAP_IR_BYPASS, instr);
    walk(8'h01, 3);
    scan(32'h0000_0005, 3);
    chk("bypass_delay", 32'h0000_0002, dout);
  endtask

  task automatic t_async_reset();
    walk(8'h01, 3);
    i_scan_ctrl_model.step(1'b0, 1'b1, o, oe);
    chk("oe_shift_dr", 32'h1, oe);
    trst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe_under_trst", 32'h0, tdo_oe);
    chk("instr_under_trst", `TAP_IR_IDCODE, instr);
    trst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ready_after_trst", 32'h1, tap_ready);
  endtask

  // chip reset alone leaves the port closed; a test reset tied to it opens it
  task automatic t_chip_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ready_after_rst", 32'h0, tap_ready);
    chk("oe_after_rst", 32'h0, tdo_oe);
    rst <= 1'b1;
    trst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    trst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ready_tied_reset", 32'h1, tap_ready);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_five_high();
    t_id_read();
    t_ir_bypass();
    t_async_reset();
    t_chip_reset();
    results();
  end

  // about 65 scan periods of 65 ns are expected
  initial begin
    #100us;
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
